// *** addr_break_pkg.sv ***
// Package for the address break comparator: register map, fields, encodings
package addr_break_pkg;

    localparam logic [1:0]  OFS_CONTROL      = 2'h0;
    localparam logic [1:0]  OFS_STATUS       = 2'h1;
    localparam logic [1:0]  OFS_ADDRESS      = 2'h2;
    localparam logic [1:0]  OFS_DATA         = 2'h3;

    localparam logic [7:0]  CONTROL_RESET    = 8'h80;
    localparam logic [15:0] ADDRESS_RESET    = 16'hffff;
    localparam logic [15:0] DATA_RESET       = 16'h0000;
    localparam logic [5:0]  STATUS_RSVD_ONES = 6'h3f;

    localparam int          RTI_ENABLE_BIT   = 7;
    localparam int          FLAG_BIT         = 7;
    localparam int          ENABLE_BIT       = 6;

    localparam logic [1:0]  CSEL_EXEC        = 2'h0;
    localparam logic [1:0]  CSEL_READ        = 2'h1;
    localparam logic [1:0]  CSEL_WRITE       = 2'h2;
    localparam logic [1:0]  CSEL_RDWR        = 2'h3;

    localparam logic [2:0]  ACMP_16          = 3'h0;
    localparam logic [2:0]  ACMP_12          = 3'h1;
    localparam logic [2:0]  ACMP_8           = 3'h2;
    localparam logic [2:0]  ACMP_4           = 3'h3;

    localparam logic [1:0]  DCMP_NONE        = 2'h0;
    localparam logic [1:0]  DCMP_LOW         = 2'h1;
    localparam logic [1:0]  DCMP_HIGH        = 2'h2;
    localparam logic [1:0]  DCMP_WORD        = 2'h3;

    typedef struct packed {
        logic       return_interrupt_enable;
        logic [1:0] cycle_select;
        logic [2:0] address_compare;
        logic [1:0] data_compare;
    } control_t;

    // One CPU bus cycle as seen by the comparator
    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        read;
        logic        write;
        logic        word;
        logic        io8;
        logic [15:0] addr;
        logic [15:0] data;
    } bus_cycle_t;

    typedef struct packed {
        control_t    control;
        logic        flag;
        logic        flag_seen;
        logic        irq_enable;
        logic [15:0] address;
        logic [15:0] data;
        logic        rte_block;
        logic [7:0]  rdata;
    } state_t;

endpackage : addr_break_pkg

// *** address_break_comparator.sv ***
// Address break comparator: bus watcher, break registers and request logic
// Notes on behaviour
// - Break request ignores CPU global interrupt mask
// - Return-interrupt enable low blocks interrupts after return
// - Cycle select picks fetch, read, write, either
// - Address compare matches 16, 12, 8, 4 bits
// - Data compare: none, low, high, full word
// - Memory lanes: even word high, odd low, bytes high
// - Word to 8-bit I/O is two byte accesses
// - Matching bus cycle sets the break flag
// - Flag clears by zero write after reading one
// - Request while flag and enable both set
// - Status low six bits read as one
// - Break address 16 bits, resets to all ones
// - High data byte to upper lane, low to lower
// - Break data register has undefined reset value; here it resets to 0000
// - Exception starts after current instruction completes
`timescale 1ns/100ps
`default_nettype none

module address_break_comparator
    import addr_break_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // Register port
    input  wire logic [1:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // CPU internal bus monitor
    input  wire bus_cycle_t bus_i,
    // Instruction sequencing from the CPU
    input  wire logic       rte_done_i,
    input  wire logic       insn_done_i,
    // Request to the CPU
    output logic            break_irq_o,
    output logic            other_irq_gate_o
);

    state_t state_reg;
    state_t state_next;

    // Both bytes of each 16-bit register share one index; writes shift in, high byte first
    logic       wr_hi;
    logic       hit_cycle;
    logic       hit_addr;
    logic       hit_data;
    logic       lane_upper;
    logic [7:0] lane_byte;
    logic [15:0] addr_mask;

    function automatic logic [15:0] mask_for(input logic [2:0] sel);
        unique case (sel)
            ACMP_16: mask_for = 16'hffff;
            ACMP_12: mask_for = 16'hfff0;
            ACMP_8:  mask_for = 16'hff00;
            ACMP_4:  mask_for = 16'hf000;
            default: mask_for = 16'hffff; // Prohibited codes: full compare
        endcase
    endfunction : mask_for

    always_comb begin
        unique case (state_reg.control.cycle_select)
            CSEL_EXEC:  hit_cycle = bus_i.fetch;
            CSEL_READ:  hit_cycle = bus_i.read;
            CSEL_WRITE: hit_cycle = bus_i.write;
            CSEL_RDWR:  hit_cycle = bus_i.read | bus_i.write;
        endcase
    end

    // (prohibited codes fall back to full compare)
    assign addr_mask = mask_for(state_reg.control.address_compare);
    assign hit_addr  = ((bus_i.addr ^ state_reg.address) & addr_mask)
                       == 16'h0000;

    // Bytes and word-to-8-bit-I/O ride the upper lane; even words too
    assign lane_upper = !bus_i.word | bus_i.io8 | !bus_i.addr[0];
    assign lane_byte  = lane_upper ? bus_i.data[15:8] : bus_i.data[7:0];

    always_comb begin
        unique case (state_reg.control.data_compare)
            DCMP_NONE: hit_data = 1'b1;
            DCMP_LOW:  hit_data = !lane_upper &&
                                  lane_byte == state_reg.data[7:0];
            DCMP_HIGH: hit_data = lane_upper &&
                                  lane_byte == state_reg.data[15:8];
            DCMP_WORD: hit_data = bus_i.data == state_reg.data;
        endcase
    end

    assign wr_hi = reg_wr_i;

    always_comb begin
        state_next       = state_reg;
        state_next.rdata = 8'h00;

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_CONTROL: state_next.rdata = state_reg.control;
                OFS_STATUS: begin
                    state_next.rdata = {state_reg.flag, state_reg.irq_enable,
                                        STATUS_RSVD_ONES};
                    if (state_reg.flag) begin
                        state_next.flag_seen = 1'b1;
                    end
                end
                OFS_ADDRESS: state_next.rdata = state_reg.address[7:0];
                OFS_DATA:    state_next.rdata = state_reg.data[7:0];
            endcase
        end

        if (wr_hi) begin
            unique case (reg_addr_i)
                OFS_CONTROL: state_next.control = control_t'(reg_wdata_i);
                OFS_STATUS: begin
                    state_next.irq_enable = reg_wdata_i[ENABLE_BIT];
                    if (!reg_wdata_i[FLAG_BIT] && state_reg.flag_seen) begin
                        state_next.flag      = 1'b0;
                        state_next.flag_seen = 1'b0;
                    end
                end
                // Address and data shift in a byte at a time, low byte last
                OFS_ADDRESS: state_next.address = {state_reg.address[7:0],
                                                   reg_wdata_i};
                OFS_DATA:    state_next.data = {state_reg.data[7:0],
                                                reg_wdata_i};
            endcase
        end

        // Set wins over a clear in the same cycle
        if (bus_i.valid && hit_cycle && hit_addr && hit_data) begin
            state_next.flag = 1'b1;
        end

        // Block other interrupts after return until one instruction retires
        if (rte_done_i && !state_reg.control.return_interrupt_enable) begin
            state_next.rte_block = 1'b1;
        end else if (insn_done_i) begin
            state_next.rte_block = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_reg.control    <= CONTROL_RESET;
            state_reg.flag       <= 1'b0;
            state_reg.flag_seen  <= 1'b0;
            state_reg.irq_enable <= 1'b0;
            state_reg.address    <= ADDRESS_RESET;
            state_reg.data       <= DATA_RESET;
            state_reg.rte_block  <= 1'b0;
            state_reg.rdata      <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // No CPU mask bit enters here; CPU takes it at instruction end
    assign break_irq_o      = state_reg.flag &
                              state_reg.irq_enable;
    // Setting the enable lifts a pending hold-off at once, not one insn later
    assign other_irq_gate_o = !state_reg.rte_block ||
                              state_reg.control.return_interrupt_enable;
    assign reg_rdata_o      = state_reg.rdata;

endmodule : address_break_comparator

`default_nettype wire

// *** abc_properties.sv ***
// Port-level assertions for the address break comparator
`timescale 1ns/100ps
`default_nettype none
module abc_properties import addr_break_pkg::*; (
    input wire logic       ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i, reg_rdata_o,
    input wire bus_cycle_t bus_i,
    input wire logic       rte_done_i, insn_done_i,
    input wire logic       break_irq_o, other_irq_gate_o
);
    logic rti_en_reg;
    // Shadow of the return-interrupt enable, not visible at the ports
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i)
            rti_en_reg <= 1'b1;
        else if (reg_wr_i && reg_addr_i == OFS_CONTROL)
            rti_en_reg <= reg_wdata_i[RTI_ENABLE_BIT];
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence st_rd; reg_rd_i && reg_addr_i == OFS_STATUS; endsequence
    sequence rte_blk; rte_done_i && !rti_en_reg; endsequence
    chk_rsvd_ones: assert property (st_rd |=> reg_rdata_o[5:0] == 6'h3f)
        else $error("reserved status bits not one");
    chk_irq_status: assert property (st_rd |=>
        (reg_rdata_o[FLAG_BIT] && reg_rdata_o[ENABLE_BIT]) ==
        $past(break_irq_o))
        else $error("request differs from flag and enable");
    chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read slot");
    chk_gate_block: assert property (rte_blk |=> !other_irq_gate_o)
        else $error("interrupts not held off after return");
    chk_gate_open: assert property (rti_en_reg |-> other_irq_gate_o)
        else $error("interrupts held off while enabled");
    chk_gate_restore: assert property (!other_irq_gate_o && insn_done_i
        && !rte_done_i |=> other_irq_gate_o) else $error("gate not reopened");
    chk_irq_hold: assert property (break_irq_o && !reg_wr_i |=>
        break_irq_o) else $error("request dropped without a write");
    chk_irq_cause: assert property ($rose(break_irq_o) |->
        $past(bus_i.valid) || $past(reg_wr_i))
        else $error("request without cause");
endmodule : abc_properties
bind address_break_comparator abc_properties chk_u (.*);
`default_nettype wire

// *** cpu_bus_model.sv ***
// Partner model of the CPU core driving the internal buses
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model import addr_break_pkg::*; (
    input  wire logic     ref_clk_i,
    output var bus_cycle_t bus_o,
    output var logic      rte_o,
    output var logic      insn_o
);
    initial begin
        bus_o = '0;
        rte_o = 1'b0;
        insn_o = 1'b0;
    end
    // Idle cycles show inverted address and data so stale values never match
    task automatic one(input logic [4:0] k, input logic [15:0] a, d);
        @(posedge ref_clk_i);
        bus_o <= {1'b1, k, a, d};
        @(posedge ref_clk_i);
        bus_o <= {1'b0, 5'h00, ~a, ~d};
    endtask : one
    // Kind is fetch, read, write, word, io8 from bit 4 down
    task automatic cyc(input logic [7:0] k, input logic [15:0] a, d);
        if (k[1] && k[0]) begin
            one(k[4:0] & 5'h1d, a, {d[15:8], 8'h00});
            one(k[4:0] & 5'h1d, a + 16'h0001, {d[7:0], 8'h00});
        end else
            one(k[4:0], a, d);
    endtask : cyc
    task automatic ins(input logic r);
        @(posedge ref_clk_i);
        rte_o <= r;
        insn_o <= !r;
        @(posedge ref_clk_i);
        rte_o <= 1'b0;
        insn_o <= 1'b0;
    endtask : ins
endmodule : cpu_bus_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the address break comparator
`timescale 1ns/100ps
`default_nettype none
module tb import addr_break_pkg::*; ;
    typedef struct packed {
        logic [7:0] c; logic [15:0] b, d; logic [7:0] k;
        logic [15:0] a, x; logic [3:0] e;
    } vec_t;
    // Control, address, data, kind, bus address, bus data, expected
    vec_t tv [16] = '{84'h80_1234_0000_10_1234_0000_1,
        84'h80_1234_0000_10_1235_0000_0, 84'h84_1234_0000_10_123f_0000_1,
        84'h8c_1234_0000_10_1fff_0000_1, 84'h88_1234_0000_10_1334_0000_0,
        84'ha0_1234_0000_0a_1234_5555_1, 84'ha0_1234_0000_06_1234_5555_0,
        84'hc0_1234_0000_06_1234_5555_1, 84'he0_1234_0000_0a_1234_5555_1,
        84'h80_1234_0000_0a_1234_5555_0, 84'ha1_1235_00ab_0a_1235_00ab_1,
        84'ha1_1234_00ab_0a_1234_00ab_0, 84'ha2_1235_ab00_08_1235_ab00_1,
        84'ha3_1234_abcd_0a_1234_abce_0, 84'ha3_1234_abcd_0a_1234_abcd_1,
        84'ha2_1235_cd00_0b_1234_abcd_1};
    logic       ref_clk_i = 1'b0, sys_rst_i = 1'b1;
    logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [1:0] reg_addr_i = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, q;
    logic       break_irq_o, other_irq_gate_o, rte_done_i, insn_done_i;
    bus_cycle_t bus_i;
    int         fails = 0, num_checks = 0, cyc_n = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    address_break_comparator dut_u (.*);
    cpu_bus_model cpu_u (.ref_clk_i, .bus_o(bus_i), .rte_o(rte_done_i),
        .insn_o(insn_done_i));
    task automatic chk(input string n, input logic [7:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 q = reg_rdata_o;
    endtask : rd
    task automatic setup(input logic [7:0] c, input logic [15:0] b, d);
        wr(OFS_CONTROL, c);
        wr(OFS_ADDRESS, b[15:8]);
        wr(OFS_ADDRESS, b[7:0]);
        wr(OFS_DATA, d[15:8]);
        wr(OFS_DATA, d[7:0]);
        wr(OFS_STATUS, 8'h40);
    endtask : setup
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic t_reset;
        rd(OFS_STATUS);
        chk("rst_status", q, 8'h3f);
        chk("rst_irq", break_irq_o, 8'h00);
        chk("rst_gate", other_irq_gate_o, 8'h01);
        rd(OFS_CONTROL);
        chk("rst_control", q, 8'h80);
        rd(OFS_ADDRESS);
        chk("rst_address", q, 8'hff);
    endtask : t_reset
    task automatic t_table;
        foreach (tv[i]) begin
            setup(tv[i].c, tv[i].b, tv[i].d);
            cpu_u.cyc(tv[i].k, tv[i].a, tv[i].x);
            @(posedge ref_clk_i);
            #1 chk("irq", break_irq_o, tv[i].e);
            rd(OFS_STATUS);
            chk("status", q, {tv[i].e[0], 7'h7f});
            wr(OFS_STATUS, 8'h40);
            chk("cleared", break_irq_o, 8'h00);
        end
    endtask : t_table
    task automatic t_clear;
        setup(8'h80, 16'h1234, 16'h0000);
        cpu_u.cyc(8'h10, 16'h1234, 16'h0000);
        wr(OFS_STATUS, 8'h40);
        chk("no_read", break_irq_o, 8'h01);
        wr(OFS_STATUS, 8'h00);
        chk("masked", break_irq_o, 8'h00);
        wr(OFS_STATUS, 8'hc0);
        chk("unmasked", break_irq_o, 8'h01);
        rd(OFS_STATUS);
        wr(OFS_STATUS, 8'h40);
        chk("read_clear", break_irq_o, 8'h00);
    endtask : t_clear
    task automatic t_rte;
        wr(OFS_CONTROL, 8'h00);
        cpu_u.ins(1'b1);
        #1 chk("gate_rte", other_irq_gate_o, 8'h00);
        cpu_u.ins(1'b0);
        #1 chk("gate_next", other_irq_gate_o, 8'h01);
        wr(OFS_CONTROL, 8'h80);
        cpu_u.ins(1'b1);
        #1 chk("gate_on", other_irq_gate_o, 8'h01);
    endtask : t_rte
    always @(posedge ref_clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_table;
        t_clear;
        t_rte;
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
